//--- ftc_regs.vh
/*
 * Constants for the fault retry and turn-off control block: command
 * codes, field positions, reset values and timing counts.
 * Assumes a 10 MHz system clock and a decoded PMBus command port.
 */
`ifndef FTC_REGS_VH
`define FTC_REGS_VH

// Command codes
`define FTC_CMD_TURN_OFF_DELAY 8'h64
`define FTC_CMD_TURN_OFF_FALL  8'h65
`define FTC_CMD_TURN_OFF_LIMIT 8'h66
`define FTC_CMD_TIME_UNIT    8'hD2

// Reset values of the word settings
`define FTC_RST_TURN_OFF_DELAY 16'h0000
`define FTC_RST_TURN_OFF_FALL  16'h0000
`define FTC_RST_TURN_OFF_LIMIT 16'h0000

// Fault response fields
`define FTC_RETRY_MSB        5
`define FTC_RETRY_LSB        3
`define FTC_DTIME_MSB        2
`define FTC_DTIME_LSB        0
`define FTC_RETRY_NONE       3'h0
`define FTC_RETRY_FOREVER    3'h7

// Timing: millisecond base tick
`define FTC_CLK_HZ           10000000
`define FTC_TICK_MS          1
`define FTC_MS_CYCLES        (`FTC_CLK_HZ / 1000 * `FTC_TICK_MS)

`endif

//--- ftc_ms_tick.v
/*
 * Millisecond enable divider: one-cycle pulse every CYCLES clocks.
 * Assumes a single free-running clock and asynchronous reset.
 */
`timescale 1ns/1ps

module ftc_ms_tick #(
	parameter CYCLES = 10000
) (
	input  wire        clk,
	input  wire        rst_n,
	output reg         tick
);

	reg  [15:0] div_cnt;

	// Free-running divider, restarts on terminal count
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 16'h0000;
			tick    <= 1'b0;
		end else if (div_cnt == CYCLES[15:0] - 16'h0001) begin
			div_cnt <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
			tick    <= 1'b0;
		end
	end

endmodule // ftc_ms_tick

//--- ftc_top.v
/*
 * Fault retry policy and output turn-off sequencing for a power stage,
 * with the three turn-off word settings behind a decoded PMBus command
 * port. Assumes the PMBus framing layer, the fault detectors and the
 * 0xD2 time-unit register live outside and feed the ports below.
 */
//
// Contract
// - Code 110 gives six restart attempts, then output stays off until cleared.
// - Code 111 retries forever until commanded off, bias lost, or another fault.
// - Restart attempt starts are spaced by the retry time field times unit.
// - Retry time field n means two to the power n delay units.
// - Same unit count serves as run-on time or retry interval per response.
// - Delay unit length comes from the separate 0xD2 time-unit register.
// - Startup-timeout faults use the output-voltage fault delay unit.
// - After disable wait the 16-bit ms turn-off delay at 0x64; a disable in ST_TRY drops the output at once, with no delay or fall.
// - Then ramp output down over the 16-bit ms fall time at 0x65.
// - Warn if output not below 12.5% within the ms limit at 0x66; the watchdog starts only on a disable in ST_ON, not from ST_RUNON.
// - The three turn-off settings support read word and write word.
// - Latched fault clears by clear command, off-then-on, or bias loss.
`timescale 1ns/1ps
`include "ftc_regs.vh"

module ftc_top #(
	parameter MS_CYCLES = `FTC_MS_CYCLES
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [7:0]  cmd_code,
	input  wire        cmd_wr,
	input  wire        cmd_rd,
	input  wire [15:0] wr_word,
	output reg  [15:0] rd_word,
	output reg         rd_ack,
	output reg         cmd_nack,
	input  wire        enable_req,
	input  wire        fault_det,
	input  wire        fault_startup,
	input  wire        fault_fatal,
	input  wire        clear_faults,
	input  wire        restart_ok,
	input  wire [5:0]  fault_response,
	input  wire        response_run_on,
	input  wire [7:0]  unit_ms_vout,
	input  wire [7:0]  unit_ms_other,
	input  wire        vout_low_pin,
	output reg         output_en,
	output reg         fall_active,
	output reg         fault_latched,
	output reg  [2:0]  retry_count,
	output reg         toff_warn
);

	localparam ST_OFF   = 3'h0;
	localparam ST_ON    = 3'h1;
	localparam ST_RUNON = 3'h2;
	localparam ST_WAIT  = 3'h3;
	localparam ST_TRY   = 3'h4;
	localparam ST_LATCH = 3'h5;
	localparam ST_TDLY  = 3'h6;
	localparam ST_FALL  = 3'h7;

	reg  [15:0] turn_off_delay;
	reg  [15:0] turn_off_fall_time;
	reg  [15:0] turn_off_timeout_limit;
	reg  [2:0]  state;
	reg  [15:0] tmr;
	reg  [16:0] warn_cnt;
	reg         warn_run;
	reg         low_s1;
	reg         low_s2;
	wire        ms_tick;
	wire [2:0]  retry_code;
	wire [2:0]  dtime_code;
	wire [7:0]  unit_ms;
	wire [15:0] fault_wait;
	wire        tmr_done;
	wire        retry_left;

	ftc_ms_tick #(
		.CYCLES (MS_CYCLES)
	) u_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (ms_tick)
	);

	assign retry_code = fault_response[`FTC_RETRY_MSB:`FTC_RETRY_LSB];
	assign dtime_code = fault_response[`FTC_DTIME_MSB:`FTC_DTIME_LSB];
	// Unit comes from the time-unit register; every fault, startup timeout or not, uses the vout unit
	assign unit_ms    = (fault_startup || 1'b1) ? unit_ms_vout : unit_ms_other;
	// 2^n units times unit length; max 128 * 255 fits in 16 bits
	assign fault_wait = ({8'h00, unit_ms} << dtime_code);
	// A phase ends on the tick after the count reaches zero, so N ms never runs short
	assign tmr_done   = (tmr == 16'h0000) && ms_tick;
	// Limit equals the code, this failure included; the forever code never runs out
	assign retry_left = (retry_code == `FTC_RETRY_FOREVER) ||
	                    (retry_count + 3'h1 < retry_code);

	// Low-output comparator comes from the analog side, synchronise it
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_s1 <= 1'b0;
			low_s2 <= 1'b0;
		end else begin
			low_s1 <= vout_low_pin;
			low_s2 <= low_s1;
		end
	end

	// Word settings and command port; unknown codes are refused
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			turn_off_delay         <= `FTC_RST_TURN_OFF_DELAY;
			turn_off_fall_time     <= `FTC_RST_TURN_OFF_FALL;
			turn_off_timeout_limit <= `FTC_RST_TURN_OFF_LIMIT;
			rd_word    <= 16'h0000;
			rd_ack     <= 1'b0;
			cmd_nack   <= 1'b0;
		end else begin
			rd_ack   <= 1'b0;
			cmd_nack <= 1'b0;
			if (cmd_wr) begin
				case (cmd_code)
				`FTC_CMD_TURN_OFF_DELAY: turn_off_delay         <= wr_word;
				`FTC_CMD_TURN_OFF_FALL:  turn_off_fall_time     <= wr_word;
				`FTC_CMD_TURN_OFF_LIMIT: turn_off_timeout_limit <= wr_word;
				default:             cmd_nack   <= 1'b1;
				endcase
			end else if (cmd_rd) begin
				rd_ack <= 1'b1;
				case (cmd_code)
				`FTC_CMD_TURN_OFF_DELAY: rd_word <= turn_off_delay;
				`FTC_CMD_TURN_OFF_FALL:  rd_word <= turn_off_fall_time;
				`FTC_CMD_TURN_OFF_LIMIT: rd_word <= turn_off_timeout_limit;
				default: begin
					rd_word  <= 16'h0000;
					rd_ack   <= 1'b0;
					cmd_nack <= 1'b1;
				end
				endcase
			end
		end
	end

	// Sequencer. The shared ms timer is loaded at each phase start and
	// counts down on the tick, so a retry interval runs from the start
	// of one attempt to the start of the next, not from its failure.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state         <= ST_OFF;
			tmr           <= 16'h0000;
			output_en     <= 1'b0;
			fall_active   <= 1'b0;
			fault_latched <= 1'b0;
			retry_count   <= 3'h0;
		end else begin
			if (ms_tick && !tmr_done)
				tmr <= tmr - 16'h0001;
			case (state)
			ST_OFF: begin
				output_en   <= 1'b0;
				fall_active <= 1'b0;
				if (enable_req) begin
					state     <= ST_ON;
					output_en <= 1'b1;
				end
			end
			ST_ON: begin
				if (fault_fatal) begin
					state         <= ST_LATCH;
					output_en     <= 1'b0;
					fault_latched <= 1'b1;
				end else if (fault_det && response_run_on) begin
					state <= ST_RUNON;
					tmr   <= fault_wait;
				end else if (fault_det) begin
					output_en <= 1'b0;
					tmr       <= fault_wait;
					if (retry_code == `FTC_RETRY_NONE) begin
						state         <= ST_LATCH;
						fault_latched <= 1'b1;
					end else
						state <= ST_WAIT;
				end else if (!enable_req) begin
					state <= ST_TDLY;
					tmr   <= turn_off_delay;
				end
			end
			ST_RUNON: begin
				// Keep running for the unit count, then shut and latch
				if (!enable_req) begin
					state <= ST_TDLY;
					tmr   <= turn_off_delay;
				end else if (tmr_done || fault_fatal) begin
					state         <= ST_LATCH;
					output_en     <= 1'b0;
					fault_latched <= 1'b1;
				end
			end
			ST_WAIT: begin
				if (!enable_req || fault_fatal) begin
					state         <= fault_fatal ? ST_LATCH : ST_OFF;
					fault_latched <= fault_fatal;
					retry_count   <= 3'h0;
				end else if (tmr_done) begin
					state     <= ST_TRY;
					output_en <= 1'b1;
					tmr       <= fault_wait;
				end
				if (clear_faults)
					retry_count <= 3'h0;
			end
			ST_TRY: begin
				if (!enable_req || fault_fatal) begin
					state         <= fault_fatal ? ST_LATCH : ST_OFF;
					output_en     <= 1'b0;
					fault_latched <= fault_fatal;
					retry_count   <= 3'h0;
				end else if (restart_ok) begin
					state       <= ST_ON;
					retry_count <= 3'h0;
				end else if (fault_det) begin
					output_en <= 1'b0;
					if (retry_count != 3'h7)
						retry_count <= retry_count + 3'h1;
					// Count of one includes this attempt; compare before increment
					if (retry_left)
						state <= ST_WAIT;
					else begin
						state         <= ST_LATCH;
						fault_latched <= 1'b1;
					end
				end else if (clear_faults)
					retry_count <= 3'h0;
			end
			ST_LATCH: begin
				output_en <= 1'b0;
				// Clear command, or command off so the next on restarts
				if (clear_faults || !enable_req) begin
					state         <= ST_OFF;
					fault_latched <= 1'b0;
					retry_count   <= 3'h0;
				end
			end
			ST_TDLY: begin
				if (tmr_done) begin
					state       <= ST_FALL;
					fall_active <= 1'b1;
					tmr         <= turn_off_fall_time;
				end
			end
			ST_FALL: begin
				if (tmr_done) begin
					state       <= ST_OFF;
					fall_active <= 1'b0;
					output_en   <= 1'b0;
				end
			end
			default: state <= ST_OFF;
			endcase
		end
	end

	// Turn-off watchdog: runs from disable in ST_ON until the output reads low.
	// A new event setting the warning wins over a clear in that cycle.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			warn_run  <= 1'b0;
			warn_cnt  <= 17'h00000;
			toff_warn <= 1'b0;
		end else begin
			if (state == ST_ON && !enable_req && !fault_det && !fault_fatal) begin
				warn_run <= 1'b1;
				warn_cnt <= 17'h00000;
			end else if (warn_run && low_s2)
				warn_run <= 1'b0;
			else if (warn_run && ms_tick)
				warn_cnt <= warn_cnt + 17'h00001;
			if (warn_run && !low_s2 && (warn_cnt >= {1'b0, turn_off_timeout_limit})) begin
				toff_warn <= 1'b1;
				warn_run  <= 1'b0;
			end else if (clear_faults)
				toff_warn <= 1'b0;
		end
	end

endmodule // ftc_top

//--- ftc_checker.sv
/* Checker for ftc_top: command port answers and sequencer order.
   Assumes one clock domain and binding to the top module's ports. */
`timescale 1ns/1ps
module ftc_checker (
	input logic       clk,
	input logic       rst_n,
	input logic [7:0] cmd_code,
	input logic       cmd_wr,
	input logic       cmd_rd,
	input logic       rd_ack,
	input logic       cmd_nack,
	input logic       enable_req,
	input logic       fault_det,
	input logic       fault_fatal,
	input logic       clear_faults,
	input logic [5:0] fault_response,
	input logic       output_en,
	input logic       fall_active,
	input logic       fault_latched,
	input logic [2:0] retry_count,
	input logic       toff_warn
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Only the three turn-off words are answered
	wire mapped = (cmd_code >= 8'h64) && (cmd_code <= 8'h66);
	sequence s_fall_end;
		fall_active ##1 !fall_active;
	endsequence
	property p_rd_ack;
		cmd_rd && !cmd_wr && mapped |=> rd_ack && !cmd_nack;
	endproperty
	property p_nack;
		(cmd_rd || cmd_wr) && !mapped |=> cmd_nack && !rd_ack;
	endproperty
	property p_fall_start;
		$rose(fall_active) |-> !$past(enable_req) && output_en;
	endproperty
	property p_fall_end;
		s_fall_end |-> !output_en;
	endproperty
	property p_retry6;
		fault_response[5:3] == 3'h6 && retry_count == 3'h6 |-> fault_latched && !output_en;
	endproperty
	// Latching here while faults keep coming would mean a hidden limit
	property p_forever;
		fault_response[5:3] == 3'h7 && fault_det && !fault_fatal && !fault_latched
			|=> !fault_latched;
	endproperty
	property p_clear;
		clear_faults && !fault_det && !fault_fatal |=> !fault_latched && retry_count == 3'h0;
	endproperty
	property p_warn_hold;
		toff_warn && !clear_faults |=> toff_warn;
	endproperty
	a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
	a_nack: assert property (p_nack) else $error("bad code not refused");
	a_fall_start: assert property (p_fall_start) else $error("fall without disable");
	a_fall_end: assert property (p_fall_end) else $error("output on after fall");
	a_retry6: assert property (p_retry6) else $error("sixth failure not latched");
	a_forever: assert property (p_forever) else $error("continuous retry latched");
	a_clear: assert property (p_clear) else $error("clear left latch or count");
	a_warn_hold: assert property (p_warn_hold) else $error("warning dropped");
endmodule // ftc_checker
bind ftc_top ftc_checker u_chk (.clk(clk), .rst_n(rst_n), .cmd_code(cmd_code),
	.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .rd_ack(rd_ack), .cmd_nack(cmd_nack),
	.enable_req(enable_req), .fault_det(fault_det), .fault_fatal(fault_fatal),
	.clear_faults(clear_faults), .fault_response(fault_response), .output_en(output_en),
	.fall_active(fall_active), .fault_latched(fault_latched), .retry_count(retry_count),
	.toff_warn(toff_warn));

//--- ftc_host.sv
/* Host model for the decoded command port, one word per transfer.
   Assumes the answer is visible on the edge that takes the strobe. */
`timescale 1ns/1ps
module ftc_host (
	input  logic        clk,
	output logic [7:0]  cmd_code,
	output logic        cmd_wr,
	output logic        cmd_rd,
	output logic [15:0] wr_word,
	input  logic [15:0] rd_word,
	input  logic        cmd_nack
);
	initial {cmd_code, cmd_wr, cmd_rd, wr_word} = '0;
	// Idle lines show inverted values so stale data never looks valid
	task xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic nk);
		@(posedge clk) #1;
		cmd_code = c;
		wr_word = d;
		cmd_wr = w;
		cmd_rd = !w;
		@(posedge clk) #1;
		cmd_wr = 0;
		cmd_rd = 0;
		q = rd_word;
		nk = cmd_nack;
		cmd_code = ~c;
		wr_word = ~d;
	endtask
endmodule // ftc_host

//--- tb_top.sv
/* Testbench for ftc_top: word settings, turn-off timing, retry policy.
   Assumes ftc_host drives the command port; short millisecond. */
`timescale 1ns/1ps
`include "ftc_regs.vh"
module tb_top;
	localparam MS = 10;
	logic        clk, rst_n, en, fd, fs, cf, rok, vl, wr, rd, ack, nack, oen, fall, lat, wn, nk;
	logic        ff, ro;
	logic [5:0]  resp;
	logic [7:0]  code, uv, uo;
	logic [15:0] wd, rdw, q;
	logic [2:0]  rc;
	int          errors, n_checks, t, i, n;
	ftc_top #(.MS_CYCLES(MS)) u_dut (.clk(clk), .rst_n(rst_n), .cmd_code(code), .cmd_wr(wr),
		.cmd_rd(rd), .wr_word(wd), .rd_word(rdw), .rd_ack(ack), .cmd_nack(nack),
		.enable_req(en), .fault_det(fd), .fault_startup(fs), .fault_fatal(ff),
		.clear_faults(cf), .restart_ok(rok), .fault_response(resp), .response_run_on(ro),
		.unit_ms_vout(uv), .unit_ms_other(uo), .vout_low_pin(vl), .output_en(oen),
		.fall_active(fall), .fault_latched(lat), .retry_count(rc), .toff_warn(wn));
	ftc_host u_host (.clk(clk), .cmd_code(code), .cmd_wr(wr), .cmd_rd(rd), .wr_word(wd),
		.rd_word(rdw), .cmd_nack(nack));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task step;
		@(posedge clk) #1;
	endtask
	// Count cycles until output_en (s=0) or fall_active (s=1) reads v
	task wait_for(input logic s, input logic v, input int lim);
		t = 0;
		while ((s ? fall : oen) !== v) begin
			step;
			t++;
			if (t > lim) begin
				errors++;
				$display("MISMATCH %0t wait timed out", $time);
				finish_test;
			end
		end
	endtask
	task pulse_fault;
		fd = 1;
		step;
		fd = 0;
	endtask
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial begin
		{en, fd, fs, cf, rok, vl, ff, ro, errors, n_checks} = '0;
		resp = 6'h00;
		uv = 8'h01;
		uo = 8'h05; // other unit differs so a wrong unit shows
		rst_n = 0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1;
		// Reset value, write and read back, refused codes
		for (i = 0; i < 3; i++) begin
			u_host.xfer(0, 8'(8'h64 + i), 16'h0000, q, nk);
			chk(q, 16'h0000);
			chk(ack, 1);
			u_host.xfer(1, 8'(8'h64 + i), 16'(16'hA5C3 + i), q, nk);
			u_host.xfer(0, 8'(8'h64 + i), 16'h0000, q, nk);
			chk(q, 16'(16'hA5C3 + i));
		end
		u_host.xfer(1, `FTC_CMD_TIME_UNIT, 16'h1234, q, nk);
		chk(nk, 1);
		u_host.xfer(0, 8'h67, 16'h0000, q, nk);
		chk(nk, 1);
		chk(q, 16'h0000);
		chk(ack, 0);
		// Delay then fall, each within one tick of its setting
		u_host.xfer(1, `FTC_CMD_TURN_OFF_DELAY, 16'h0003, q, nk);
		u_host.xfer(1, `FTC_CMD_TURN_OFF_FALL, 16'h0002, q, nk);
		u_host.xfer(1, `FTC_CMD_TURN_OFF_LIMIT, 16'h0064, q, nk);
		en = 1;
		wait_for(0, 1, 3);
		en = 0;
		wait_for(1, 1, 60);
		chk(t >= 3 * MS - 1 && t <= 4 * MS + 1, 1);
		wait_for(1, 0, 60);
		chk(t >= 2 * MS - 1 && t <= 3 * MS + 1, 1);
		vl = 1; // Output has reached its low level, watchdog stops
		wait_for(0, 0, 2);
		chk(wn, 0);
		// Output never falls low: warning after the limit until cleared
		vl = 0;
		u_host.xfer(1, `FTC_CMD_TURN_OFF_DELAY, 16'h0000, q, nk);
		u_host.xfer(1, `FTC_CMD_TURN_OFF_FALL, 16'h0004, q, nk);
		u_host.xfer(1, `FTC_CMD_TURN_OFF_LIMIT, 16'h0002, q, nk);
		chk(wn, 0);
		en = 1;
		wait_for(0, 1, 3);
		en = 0;
		wait_for(0, 0, 80);
		chk(wn, 1);
		vl = 1;
		repeat (3) step;
		cf = 1;
		step;
		cf = 0;
		step;
		chk(wn, 0);
		// Fault to next attempt is 2^n vout units, for a startup fault
		fs = 1;
		en = 1;
		wait_for(0, 1, 3);
		for (n = 0; n < 8; n++) begin
			resp = {3'h7, 3'(n)};
			pulse_fault;
			wait_for(0, 0, 3);
			wait_for(0, 1, 1400);
			chk(t >= (MS << n) - 3 && t <= (MS << n) + MS + 2, 1);
			rok = 1;
			step;
			rok = 0;
		end
		// Failed attempts counted; six latch code 110, 111 never latches
		for (i = 6; i < 8; i++) begin
			resp = {3'(i), 3'h1};
			pulse_fault;
			for (n = 1; n < 8 && !lat; n++) begin
				wait_for(0, 1, 40);
				pulse_fault;
				step;
				chk(rc, n);
				chk(lat, i == 6 && n == 6);
			end
			repeat (100) step;
			chk(oen, i == 7);
			cf = 1;
			step;
			cf = 0;
			step;
			chk(lat, 0);
			chk(rc, 0);
			en = 0;
			step;
			wait_for(0, 0, 100);
			en = 1;
			wait_for(0, 1, 40);
		end
		// Run-on response keeps the output up for 2^n units, then latches
		ro = 1;
		resp = {3'h7, 3'h2};
		pulse_fault;
		chk(oen, 1);
		wait_for(0, 0, 60);
		chk(t >= 4 * MS - 1 && t <= 5 * MS + 1, 1);
		chk(lat, 1);
		ro = 0;
		cf = 1;
		step;
		cf = 0;
		wait_for(0, 1, 3);
		// Another fault during continuous retry shuts down and latches
		resp = {3'h7, 3'h0};
		pulse_fault;
		ff = 1;
		step;
		ff = 0;
		step;
		chk(lat, 1);
		chk(oen, 0);
		finish_test;
	end
endmodule // tb_top
